/* shared/conv_ctrl_pkg.sv */
// Shared constants for the converter conversion control block.
package conv_ctrl_pkg;
  localparam int RESULT_W = 10;
  localparam int CHAN_W = 5;
  localparam int REF_W = 2;
  localparam int TRIG_W = 3;
  localparam int PRESC_W = 3;
  localparam int CYC_W = 5;
  // Converter clock cycles per conversion.
  localparam logic [CYC_W-1:0] NORMAL_CYCLES = 5'h0D;
  localparam logic [CYC_W-1:0] FIRST_CYCLES = 5'h19;
  // Trigger source that relaunches on the block's own completion, whatever the completion flag holds.
  localparam logic [TRIG_W-1:0] TRIG_FREE_RUN = 3'h0;
  // Reference select encodings.
  localparam logic [REF_W-1:0] REF_EXTERNAL = 2'h0;
  localparam logic [REF_W-1:0] REF_AVCC = 2'h1;
  localparam logic [REF_W-1:0] REF_INT_2V56 = 2'h3;
  // Channel field: codes below this are single ended.
  localparam logic [CHAN_W-1:0] CHAN_SE_LIMIT = 5'h08;
  localparam logic [CHAN_W-1:0] CHAN_GAIN10_LO = 5'h08;
  localparam logic [CHAN_W-1:0] CHAN_GAIN200_LO = 5'h0C;
  localparam logic [CHAN_W-1:0] CHAN_GAIN_HI = 5'h0F;
  // Amplifier gain codes.
  localparam logic [1:0] GAIN_BYPASS = 2'h0;
  localparam logic [1:0] GAIN_X1 = 2'h1;
  localparam logic [1:0] GAIN_X10 = 2'h2;
  localparam logic [1:0] GAIN_X200 = 2'h3;
  // Result byte lanes.
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = RESULT_W;
  localparam logic [1:0] BUF_CNT_FULL = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_CONVERT = 2'b11,
    ST_FINISH = 2'b10
  } conv_state_e;
endpackage

/* rtl/result_buffer.sv */
// Two-entry buffer carrying conversion codes to the result registers.
`timescale 1ns/1ps
module result_buffer
  import conv_ctrl_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Filling side.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [BUF_W-1:0] in_data_i,
  // Draining side.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [BUF_W-1:0] out_data_o
);
  logic [BUF_W-1:0] mem_reg [BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic do_push;
  logic do_pop;

  // Handshake terms; full and empty follow the occupancy count.
  assign in_ready_o = (count_reg != BUF_CNT_FULL);
  assign out_valid_o = (count_reg != 2'h0);
  assign do_push = ce_i && in_valid_i && in_ready_o;
  assign do_pop = ce_i && out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  // Storage is written without reset since the count guards reads.
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (do_pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, do_push} - {1'b0, do_pop};
    end
  end
endmodule

/* rtl/conv_ctrl.sv */
// Conversion sequencing, triggering and result registers of the converter.
`timescale 1ns/1ps
module conv_ctrl
  import conv_ctrl_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Control bits from software.
  input wire logic converter_enable_i,
  input wire logic conversion_start_set_i,
  input wire logic auto_trigger_enable_i,
  input wire logic [TRIG_W-1:0] trigger_source_select_i,
  input wire logic left_adjust_select_i,
  input wire logic [REF_W-1:0] reference_select_i,
  input wire logic [CHAN_W-1:0] channel_gain_select_i,
  input wire logic [PRESC_W-1:0] prescale_select_i,
  input wire logic done_flag_clear_i,
  // Result byte read strobes.
  input wire logic result_low_read_i,
  input wire logic result_high_read_i,
  // Trigger sources, one per select code; code 0 is unused here.
  input wire logic [7:0] trigger_sources_i,
  // Successive approximation comparator from the analog core.
  input wire logic comparator_i,
  // Status to software.
  output logic conversion_start_o,
  output logic conversion_done_flag_o,
  output logic conversion_done_pulse_o,
  output logic [7:0] result_low_byte_o,
  output logic [7:0] result_high_byte_o,
  output logic result_lock_o,
  // Analog core control.
  output logic analog_enable_o,
  output logic sample_hold_o,
  output logic [RESULT_W-1:0] dac_code_o,
  output logic [CHAN_W-1:0] active_channel_o,
  output logic [1:0] active_gain_o,
  output logic [REF_W-1:0] active_reference_o,
  output logic reference_pin_avcc_o,
  output logic reference_pin_internal_o
);
  conv_state_e state_reg, state_next;
  logic [7:0] presc_reg;
  logic [CYC_W-1:0] cyc_reg;
  logic [CYC_W-1:0] cyc_len_reg;
  logic first_pending_reg;
  logic [RESULT_W-1:0] sar_reg;
  logic [3:0] bit_idx_reg;
  logic start_reg;
  logic done_flag_reg;
  logic lock_reg;
  logic trig_s1_reg, trig_s2_reg, trig_prev_reg;
  logic comp_s1_reg, comp_s2_reg;
  logic [RESULT_W-1:0] result_reg;
  logic [CHAN_W-1:0] chan_reg;
  logic [REF_W-1:0] ref_reg;
  logic done_pulse_reg;
  logic adc_tick;
  logic trig_sel;
  logic trig_edge;
  logic trig_fire;
  logic sw_start;
  logic begin_conv;
  logic sar_done;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [RESULT_W-1:0] buf_out_data;
  logic [RESULT_W-1:0] sar_trial;
  logic busy;
  logic free_relaunch;

  // Trigger path: pins pass two flops before the edge detector.
  assign trig_sel = trigger_sources_i[trigger_source_select_i];
  assign trig_edge = trig_s2_reg && !trig_prev_reg;
  assign trig_fire = converter_enable_i && auto_trigger_enable_i &&
    (trigger_source_select_i != TRIG_FREE_RUN) && trig_edge && !busy;
  assign sw_start = converter_enable_i && conversion_start_set_i && !busy;
  assign begin_conv = sw_start || trig_fire || free_relaunch;
  assign busy = (state_reg != ST_IDLE);

  // Prescaler tick; a trigger restarts the count so timing is fixed.
  assign adc_tick = (presc_reg == 8'h00);

  // Trial code for the current bit of the search.
  assign sar_trial = sar_reg | (RESULT_W'(1) << bit_idx_reg);
  assign sar_done = (cyc_reg == cyc_len_reg) && adc_tick;

  // Next state of the conversion sequencer.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (begin_conv) begin
          state_next = ST_START;
        end
      end
      ST_START: begin
        if (adc_tick) begin
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (sar_done) begin
          state_next = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Synchronisers for the trigger and the comparator.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      trig_s1_reg <= 1'b0;
      trig_s2_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
      comp_s1_reg <= 1'b0;
      comp_s2_reg <= 1'b0;
    end else if (ce_i) begin
      trig_s1_reg <= trig_sel;
      trig_s2_reg <= trig_s1_reg;
      trig_prev_reg <= trig_s2_reg;
      comp_s1_reg <= comparator_i;
      comp_s2_reg <= comp_s1_reg;
    end
  end

  // Prescaler: held in reset while the converter is off.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      presc_reg <= 8'h00;
    end else if (ce_i) begin
      if (!converter_enable_i) begin
        presc_reg <= 8'h00;
      end else if (trig_fire || adc_tick) begin
        presc_reg <= 8'((9'h001 << prescale_select_i) - 9'h001);
      end else begin
        presc_reg <= presc_reg - 8'h01;
      end
    end
  end

  // Sequencer, cycle counter and successive approximation register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
      cyc_len_reg <= NORMAL_CYCLES;
      first_pending_reg <= 1'b1;
      sar_reg <= '0;
      bit_idx_reg <= 4'h0;
    end else if (ce_i) begin
      state_reg <= state_next;
      if (!converter_enable_i) begin
        first_pending_reg <= 1'b1;
      end
      if (state_reg == ST_IDLE && begin_conv) begin
        cyc_len_reg <= first_pending_reg ? FIRST_CYCLES : NORMAL_CYCLES;
        first_pending_reg <= 1'b0;
        cyc_reg <= 5'h01;
        sar_reg <= '0;
        bit_idx_reg <= 4'(RESULT_W - 1);
      end else if (state_reg == ST_CONVERT && adc_tick) begin
        cyc_reg <= cyc_reg + 5'h01;
        if (cyc_reg + 5'h03 > cyc_len_reg - 5'h0A &&
            bit_idx_reg != 4'hF) begin
          // keep bit when input above trial
          sar_reg <= comp_s2_reg ? sar_trial : sar_reg;
          bit_idx_reg <= bit_idx_reg - 4'h1;
        end
      end
    end
  end

  // Start bit, completion flag, completion pulse and access lock.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_reg <= 1'b0;
      done_flag_reg <= 1'b0;
      done_pulse_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else if (ce_i) begin
      done_pulse_reg <= (state_reg == ST_FINISH);
      if (begin_conv) begin
        start_reg <= 1'b1;
      end else if (state_reg == ST_FINISH) begin
        start_reg <= auto_trigger_enable_i &&
          (trigger_source_select_i == TRIG_FREE_RUN);
      end else if (state_reg == ST_IDLE) begin
        // A free run stopped between conversions must not stay busy.
        start_reg <= 1'b0;
      end
      if (state_reg == ST_FINISH && start_reg &&
          auto_trigger_enable_i &&
          trigger_source_select_i == TRIG_FREE_RUN) begin
        start_reg <= 1'b1;
      end
      if (state_reg == ST_FINISH) begin
        done_flag_reg <= 1'b1;
      end else if (done_flag_clear_i) begin
        done_flag_reg <= 1'b0;
      end
      // low read locks, high read unlocks
      if (result_high_read_i) begin
        lock_reg <= 1'b0;
      end else if (result_low_read_i) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Free running: when idle with start held, launch the next one.
  // relaunch after own completion
  assign free_relaunch = (state_reg == ST_IDLE) && start_reg &&
    converter_enable_i && auto_trigger_enable_i &&
    (trigger_source_select_i == TRIG_FREE_RUN);

  // Channel and reference latch; frozen while converting.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      chan_reg <= '0;
      ref_reg <= REF_EXTERNAL;
    end else if (ce_i) begin
      if (converter_enable_i && (!busy || state_reg == ST_FINISH)) begin
        chan_reg <= channel_gain_select_i;
        ref_reg <= reference_select_i;
      end
    end
  end

  // Completion pushes the code into the buffer toward the result bytes.
  result_buffer u_buf (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .in_valid_i(state_reg == ST_FINISH),
    .in_ready_o(buf_in_ready),
    .in_data_i(sar_reg),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_out_ready),
    .out_data_o(buf_out_data)
  );

  // A locked result still drains the buffer, so the word is dropped.
  assign buf_out_ready = 1'b1;

  // Result register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      result_reg <= '0;
    end else if (ce_i) begin
      if (buf_out_valid && !lock_reg) begin
        result_reg <= buf_out_data;
      end
    end
  end

  assign result_low_byte_o = left_adjust_select_i ?
    {result_reg[1:0], 6'h00} : result_reg[7:0];
  assign result_high_byte_o = left_adjust_select_i ?
    result_reg[9:2] : {6'h00, result_reg[9:8]};

  assign active_gain_o = (chan_reg < CHAN_SE_LIMIT) ? GAIN_BYPASS :
    (chan_reg >= CHAN_GAIN200_LO && chan_reg <= CHAN_GAIN_HI) ?
    GAIN_X200 : (chan_reg >= CHAN_GAIN10_LO && chan_reg < CHAN_GAIN200_LO) ?
    GAIN_X10 : GAIN_X1;
  assign reference_pin_avcc_o = converter_enable_i && ref_reg == REF_AVCC;
  assign reference_pin_internal_o = converter_enable_i &&
    ref_reg == REF_INT_2V56;

  // Status and analog outputs.
  assign conversion_start_o = start_reg;
  assign conversion_done_flag_o = done_flag_reg;
  assign conversion_done_pulse_o = done_pulse_reg;
  assign result_lock_o = lock_reg;
  assign analog_enable_o = converter_enable_i;
  assign sample_hold_o = (state_reg == ST_START) ||
    (state_reg == ST_CONVERT && cyc_reg == 5'h01);
  assign dac_code_o = sar_trial;
  assign active_channel_o = chan_reg;
  assign active_reference_o = ref_reg;
endmodule

/* test/conv_ctrl_sva.sv */
// Port assertions for the conversion control block.
`timescale 1ns/1ps
module conv_ctrl_sva
  import conv_ctrl_pkg::*;
(
  // Clock, reset and controls.
  input logic clk_i,
  input logic srst_i,
  input logic ce_i,
  input logic converter_enable_i,
  input logic conversion_start_set_i,
  input logic auto_trigger_enable_i,
  input logic [TRIG_W-1:0] trigger_source_select_i,
  input logic left_adjust_select_i,
  input logic done_flag_clear_i,
  input logic result_low_read_i,
  input logic result_high_read_i,
  // Status.
  input logic conversion_start_o,
  input logic conversion_done_flag_o,
  input logic conversion_done_pulse_o,
  input logic [7:0] result_low_byte_o,
  input logic [7:0] result_high_byte_o,
  input logic result_lock_o
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Free running relaunches at completion; every other mode goes idle.
  wire free_run = auto_trigger_enable_i && converter_enable_i &&
    (trigger_source_select_i == TRIG_FREE_RUN);
  start_take_a: assert property (
    conversion_start_set_i && ce_i && converter_enable_i &&
    !conversion_start_o |=> conversion_start_o) else $error("start lost");
  busy_before_done_a: assert property (
    conversion_done_pulse_o |-> $past(conversion_start_o))
    else $error("done while idle");
  single_clear_a: assert property (
    conversion_done_pulse_o && !free_run |-> !conversion_start_o)
    else $error("start bit stuck");
  free_relaunch_a: assert property (
    conversion_done_pulse_o && free_run |-> conversion_start_o)
    else $error("free run stopped");
  flag_on_done_a: assert property (
    conversion_done_pulse_o |-> conversion_done_flag_o)
    else $error("flag missing");
  flag_sticky_a: assert property (
    conversion_done_flag_o && !done_flag_clear_i |=>
    conversion_done_flag_o) else $error("flag dropped");
  lock_set_a: assert property (
    ce_i && result_low_read_i && !result_high_read_i |=> result_lock_o)
    else $error("lock not set");
  lock_clear_a: assert property (
    ce_i && result_high_read_i |=> !result_lock_o)
    else $error("lock stuck");
  lock_hold_a: assert property (
    result_lock_o && !result_high_read_i |=>
    !$stable(left_adjust_select_i) || ($stable(result_low_byte_o) &&
    $stable(result_high_byte_o))) else $error("locked bytes moved");
endmodule
bind conv_ctrl conv_ctrl_sva chk (.clk_i, .srst_i, .ce_i,
  .converter_enable_i, .conversion_start_set_i, .auto_trigger_enable_i,
  .trigger_source_select_i, .left_adjust_select_i, .done_flag_clear_i,
  .result_low_read_i, .result_high_read_i, .conversion_start_o,
  .conversion_done_flag_o, .conversion_done_pulse_o, .result_low_byte_o,
  .result_high_byte_o, .result_lock_o);

/* test/conv_ctrl_tb.sv */
// Self-checking bench for the conversion control block.
`timescale 1ns/1ps
module conv_ctrl_tb;
  import conv_ctrl_pkg::*;
  // Stimulus, all driven on the falling edge.
  logic clk_i = 1'b0, srst_i = 1'b1, ce_i = 1'b1, enable = 1'b0;
  logic start_set = 1'b0, auto_en = 1'b0, lad = 1'b0, flag_clr = 1'b0;
  logic rd_lo = 1'b0, rd_hi = 1'b0, comp = 1'b0, c;
  logic [TRIG_W-1:0] trig_src = 3'h0;
  logic [REF_W-1:0] ref_sel = 2'h0;
  logic [CHAN_W-1:0] chan = 5'h00;
  logic [7:0] trig = 8'h00;
  // Observed outputs.
  logic busy, flag, pulse, lock, pin_avcc, pin_int, an_en, hold;
  logic [1:0] ref_o;
  logic [9:0] dac;
  logic [7:0] lo_b, hi_b;
  logic [CHAN_W-1:0] chan_o;
  logic [1:0] gain_o;
  // Bookkeeping and expectation tables.
  logic [15:0] notes [$];
  logic [15:0] e;
  int n_errors = 0, num_checks = 0, n_pulse = 0, cyc, n;
  logic [1:0] refs [3] = '{REF_EXTERNAL, REF_AVCC, REF_INT_2V56};
  logic [1:0] pins [3] = '{2'h0, 2'h2, 2'h1};
  logic [4:0] gch [7] = '{5'h00, 5'h07, 5'h08, 5'h0B, 5'h0C, 5'h0F, 5'h10};
  logic [1:0] gv [7] = '{GAIN_BYPASS, GAIN_BYPASS, GAIN_X10, GAIN_X10,
    GAIN_X200, GAIN_X200, GAIN_X1};

  conv_ctrl dut (.clk_i, .srst_i, .ce_i, .converter_enable_i(enable),
    .conversion_start_set_i(start_set), .auto_trigger_enable_i(auto_en),
    .trigger_source_select_i(trig_src), .left_adjust_select_i(lad),
    .reference_select_i(ref_sel), .channel_gain_select_i(chan),
    .prescale_select_i(3'h0), .done_flag_clear_i(flag_clr),
    .result_low_read_i(rd_lo), .result_high_read_i(rd_hi),
    .trigger_sources_i(trig), .comparator_i(comp),
    .conversion_start_o(busy), .conversion_done_flag_o(flag),
    .conversion_done_pulse_o(pulse), .result_low_byte_o(lo_b),
    .result_high_byte_o(hi_b), .result_lock_o(lock),
    .analog_enable_o(an_en), .sample_hold_o(hold), .dac_code_o(dac),
    .active_channel_o(chan_o), .active_gain_o(gain_o),
    .active_reference_o(ref_o),
    .reference_pin_avcc_o(pin_avcc), .reference_pin_internal_o(pin_int));

  // Free-running clock at 125 MHz.
  initial forever #4 clk_i = ~clk_i;

  task automatic tick(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A steady comparator settles every trial bit the same way.
  function logic [15:0] code_bytes(input logic cv, input logic l);
    logic [9:0] code;
    code = cv ? 10'h3FF : 10'h000;
    return l ? {code, 6'h00} : {6'h00, code};
  endfunction

  task start(input logic [15:0] x);
    notes.push_back(x);
    start_set = 1'b1;
    tick(1);
    start_set = 1'b0;
  endtask

  // Bounded wait; a lost completion shows as a failed count.
  task wait_done;
    cyc = 0;
    while (pulse !== 1'b1 && cyc < 300) begin
      tick(1);
      cyc++;
    end
    chk({15'h0000, cyc < 300}, 16'h0001);
  endtask

  task close_out;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Each completion retires the oldest note once the bytes have landed.
  initial forever begin
    tick(1);
    if (pulse === 1'b1) begin
      n_pulse++;
      chk({15'h0000, flag}, 16'h0001);
      tick(3);
      chk({hi_b, lo_b}, notes.size() > 0 ? notes.pop_front() : 'x);
    end
  end

  // Cut a hang short well past the expected run length.
  initial begin
    #160000;
    n_errors++;
    close_out();
  end

  initial begin
    void'($urandom(32'h8C9ED420));
    tick(8);
    srst_i = 1'b0;
    chk({hi_b, lo_b}, 16'h0000);
    chk({13'h0000, busy, flag, lock}, 16'h0000);
    $display("test reset done");
    chan = 5'h03;
    ref_sel = REF_AVCC;
    tick(4);
    chk({10'h000, chan_o, pin_avcc}, 16'h0000);
    enable = 1'b1;
    tick(4);
    chk({11'h000, chan_o}, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      ref_sel = refs[i];
      tick(4);
      chk({11'h000, an_en, ref_o, pin_avcc, pin_int},
        {11'h000, 1'b1, refs[i], pins[i]});
    end
    for (int i = 0; i < 7; i++) begin
      chan = gch[i];
      tick(4);
      chk({14'h0000, gain_o}, {14'h0000, gv[i]});
    end
    $display("test selection done");
    chan = 5'h03;
    tick(4);
    c = 1'($urandom);
    lad = 1'($urandom);
    comp = c;
    start(code_bytes(c, lad));
    chk({15'h0000, busy}, 16'h0001);
    // The search opens with the top bit on trial while sampling.
    chk({5'h00, dac, hold}, 16'h0401);
    wait_done();
    chk({15'h0000, cyc >= 25 && cyc <= 60}, 16'h0001);
    tick(4);
    // Second run changes channel midway; the old one must stay in use.
    comp = ~c;
    e = code_bytes(~c, lad);
    start(e);
    tick(3);
    chan = 5'h05;
    tick(2);
    chk({11'h000, chan_o}, 16'h0003);
    wait_done();
    chk({15'h0000, cyc + 5 >= 13 && cyc + 5 <= 24}, 16'h0001);
    tick(4);
    chk({11'h000, chan_o}, 16'h0005);
    $display("test single done");
    // Low read locks; the next result is dropped but the flag, set since the first run, stays set.
    rd_lo = 1'b1;
    tick(1);
    rd_lo = 1'b0;
    chk({15'h0000, lock}, 16'h0001);
    comp = c;
    start(e);
    wait_done();
    tick(4);
    rd_hi = 1'b1;
    tick(1);
    rd_hi = 1'b0;
    chk({15'h0000, lock}, 16'h0000);
    flag_clr = 1'b1;
    tick(1);
    flag_clr = 1'b0;
    chk({15'h0000, flag}, 16'h0000);
    start(code_bytes(c, lad));
    wait_done();
    tick(4);
    $display("test lock done");
    // Trigger edges: one starts, a second mid-run and a held level do not.
    auto_en = 1'b1;
    trig_src = 3'h2;
    n = n_pulse;
    notes.push_back(code_bytes(c, lad));
    trig[2] = 1'b1;
    tick(6);
    chk({15'h0000, busy}, 16'h0001);
    trig[2] = 1'b0;
    tick(1);
    trig[2] = 1'b1;
    wait_done();
    trig[5] = 1'b1;
    tick(40);
    chk({15'h0000, busy}, 16'h0000);
    chk(16'(n_pulse - n), 16'h0001);
    start(code_bytes(c, lad));
    chk({15'h0000, busy}, 16'h0001);
    wait_done();
    tick(4);
    $display("test trigger done");
    // Free running with the flag left set; stop by dropping auto enable.
    trig_src = TRIG_FREE_RUN;
    comp = ~c;
    e = code_bytes(~c, lad);
    start(e);
    repeat (3) begin
      wait_done();
      chk({15'h0000, busy}, 16'h0001);
      notes.push_back(e);
      tick(1);
    end
    auto_en = 1'b0;
    wait_done();
    tick(4);
    chk({15'h0000, busy}, 16'h0000);
    $display("test free run done");
    close_out();
  end
endmodule
